// >>> hw/console_pkg.sv
package console_pkg;
    // word width and function select field (bits numbered 1..16, bit 1 is the MSB)
    localparam int          WORD_W       = 16;
    localparam int          FUNC_HI_BIT  = 1;
    localparam int          FUNC_LO_BIT  = 2;
    localparam logic [1:0]  FUNC_PRINT   = 2'h1;
    localparam logic [1:0]  FUNC_LAMPS   = 2'h2;
    localparam logic [1:0]  FUNC_FORMS   = 2'h3;

    // forms command bit positions
    localparam int FORMS_LEFT_BIT   = 10;
    localparam int FORMS_RIGHT_BIT  = 12;
    localparam int FORMS_OPEN_BIT   = 13;
    localparam int FORMS_CLOSE_BIT  = 14;
    localparam int FORMS_POWER_BIT  = 15;
    localparam int FORMS_ALARM_BIT  = 16;

    // indicator command: bank selects and data field (lamp line k sits at bit DATA_BIT0+k)
    localparam int LAMP_BANK_A_BIT  = 4;
    localparam int LAMP_BANK_B_BIT  = 5;
    localparam int LAMP_BANK_C_BIT  = 6;
    localparam int LAMP_BANK_D_BIT  = 7;
    localparam int LAMP_BANK_S_BIT  = 8;
    localparam int LAMP_DATA_BIT0   = 9;
    localparam int LAMP_GROUP_W     = 8;
    localparam int LAMP_S_W         = 4;

    // print command: tilt 1,2 / rotate 1,2,4,8 / rotate extension / red ribbon
    localparam int PRINT_TILT1_BIT  = 3;
    localparam int PRINT_ROT1_BIT   = 5;
    localparam int PRINT_ROTX_BIT   = 9;
    localparam int PRINT_RED_BIT    = 10;
    localparam int TILT_W           = 2;
    localparam int ROT_W            = 4;

    // status word bit positions
    localparam int ST_DREQ_BIT      = 1;
    localparam int ST_EOP_BIT       = 2;
    localparam int ST_CARR_BIT      = 9;
    localparam int ST_FORMS_BIT     = 10;
    localparam int ST_PRINT_BIT     = 11;
    localparam int ST_KBD_BIT       = 12;
    localparam int ST_READY_BIT     = 13;
    localparam int ST_NOTHON_BIT    = 14;
    localparam int ST_OVER_BIT      = 15;
    localparam int ST_STALL_BIT     = 16;
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;

    // solenoid pulse timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int PULSE_MS      = 40;
    localparam int PULSE_CYCLES  = PULSE_MS * (CLK_HZ / 1000);

    // solenoid channel indices
    localparam int SOL_LEFT  = 0;
    localparam int SOL_RIGHT = 1;
    localparam int SOL_OPEN  = 2;
    localparam int SOL_CLOSE = 3;
    localparam int SOL_ALARM = 4;
    localparam int NUM_SOL   = 5;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] word;
    } cmd_type;

    typedef struct packed {
        logic carrier;
        logic forms;
        logic printer;
        logic keyboard;
    } dint_type;
endpackage : console_pkg

// >>> hw/console_forms_status_control.sv
`timescale 1ns/1ns
// What this block does
// - function field 11 in bits 1-2 marks a forms command, decoded as such
// - forms bit 10 pulses left platen advance output low for one line
// - forms bit 12 pulses right platen advance output low for one line
// - forms bit 13 pulses chute open solenoid output low
// - forms bit 14 pulses chute close solenoid output low
// - forms bit 15 raises the system power-off request
// - forms bit 16 pulses alarm solenoid output low
// - status bit 1 shows data request, following any data interrupt
// - status bit 2 shows paper out on either or both platens
// - status bit 9 mirrors carrier data interrupt
// - status bit 10 mirrors forms data interrupt
// - status bit 11 mirrors printer data interrupt
// - status bit 12 mirrors keyboard data interrupt
// - status bit 13 set once ready pushbutton pressed
// - status bit 14 set when key pressed while first buffer stage still full
// - status bit 15 set on overspeed after a carrier word arrived
// - status bit 16 set on stall after a carrier word arrived
// - lamp outputs active low; groups A-D eight lines, S four lines
// - head positioned by two tilt and four rotate active-low code lines
// - ribbon/rotate line is red ribbon in 64 mode, rotate bit in 96 mode
// - motor-on output driven low to run motor; power lamp held low
// - function field 10 marks an indicator command
// - lamp stays lit until same bank rewritten with zero or system clear
module console_forms_status_control
    import console_pkg::*;
#(
    parameter int PULSE_LEN = console_pkg::PULSE_CYCLES // solenoid pulse width, cycles
) (
    input  wire logic                 CLK_I,             // 20 MHz clock
    input  wire logic                 RST_I,             // sync reset, active high
    input  wire logic                 SYS_CLEAR_I,       // system clear, active high
    input  wire console_pkg::cmd_type CMD_I,             // processor_command_bus word
    input  wire console_pkg::dint_type DINT_I,           // data interrupts, active high
    input  wire logic                 EOP_LEFT_I,        // left platen out of paper
    input  wire logic                 EOP_RIGHT_I,       // right platen out of paper
    input  wire logic                 READY_BTN_I,       // ready pushbutton pressed
    input  wire logic                 KEY_STROBE_I,      // keyboard strobe pulse
    input  wire logic                 KEY_STAGE_FULL_I,  // first output stage occupied
    input  wire logic                 CARRIER_WORD_I,    // carrier data word received
    input  wire logic                 OVERSPEED_I,       // carrier too fast
    input  wire logic                 STALL_I,           // carrier too slow
    input  wire logic                 STATUS_ACK_I,      // clears sticky error bits
    input  wire logic                 MODE_96_I,         // 1: 96-char, 0: 64-char
    input  wire logic                 MOTOR_REQ_I,       // run decoder motor
    output logic [WORD_W-1:0]         STATUS_O,          // status_return_bus word
    output logic                      POWER_OFF_O,       // system power-off request
    output logic                      LEFT_FEED_DRIVE_N_O,  // left platen advance
    output logic                      RIGHT_FEED_DRIVE_N_O, // right platen advance
    output logic                      CHUTE_OPEN_DRIVE_N_O, // chute open solenoid
    output logic                      CHUTE_CLOSE_DRIVE_N_O,// chute close solenoid
    output logic                      ALARM_DRIVE_N_O,      // audible alarm solenoid
    output logic [LAMP_GROUP_W-1:0]   LAMP_GROUP_A_N_O,  // group A lamps
    output logic [LAMP_GROUP_W-1:0]   LAMP_GROUP_B_N_O,  // group B lamps
    output logic [LAMP_GROUP_W-1:0]   LAMP_GROUP_C_N_O,  // group C lamps
    output logic [LAMP_GROUP_W-1:0]   LAMP_GROUP_D_N_O,  // group D lamps
    output logic                      LAMP_ALPHA_N_O,    // alpha lamp
    output logic                      LAMP_READY_N_O,    // ready lamp
    output logic                      LAMP_ERROR_N_O,    // error lamp
    output logic                      LAMP_NUMERIC_N_O,  // numeric lamp
    output logic [TILT_W-1:0]         HEAD_TILT_CODE_N_O,   // tilt weights 1,2
    output logic [ROT_W-1:0]          HEAD_ROTATE_CODE_N_O, // rotate weights 1,2,4,8
    output logic                      RIBBON_OR_ROTATE_EXT_N_O, // shared ribbon/rotate
    output logic                      RIBBON_SHIFT_WIDE_N_O,    // 96-mode ribbon
    output logic                      DECODER_MOTOR_ON_N_O,     // motor on
    output logic                      POWER_LAMP_N_O            // power-on lamp
);
    import console_pkg::*;

    localparam int CNT_W = $clog2(PULSE_LEN + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_LEN - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // refuse a pulse width the down-counter cannot serve
    if (PULSE_LEN < 1) begin : g_bad_len
        $error("PULSE_LEN must be at least one cycle");
    end

    // command bit n (1 = MSB) picked out of a word
    function automatic logic wbit(input logic [WORD_W-1:0] w, input int n);
        return w[WORD_W-n];
    endfunction : wbit

    // function select field of a word
    function automatic logic [1:0] func_of(input logic [WORD_W-1:0] w);
        return {wbit(w, FUNC_HI_BIT), wbit(w, FUNC_LO_BIT)};
    endfunction : func_of

    logic                    forms_cmd;
    logic                    lamp_cmd;
    logic                    print_cmd;
    logic [NUM_SOL-1:0]      sol_fire;
    logic [LAMP_GROUP_W-1:0] lamp_data;

    // decode; bits 3-9 and 11 of a forms word play no part
    assign forms_cmd = CMD_I.valid && (func_of(CMD_I.word) == FUNC_FORMS);
    assign lamp_cmd  = CMD_I.valid && (func_of(CMD_I.word) == FUNC_LAMPS);
    assign print_cmd = CMD_I.valid && (func_of(CMD_I.word) == FUNC_PRINT);
    assign sol_fire[SOL_LEFT]  = forms_cmd && wbit(CMD_I.word, FORMS_LEFT_BIT);
    assign sol_fire[SOL_RIGHT] = forms_cmd && wbit(CMD_I.word, FORMS_RIGHT_BIT);
    assign sol_fire[SOL_OPEN]  = forms_cmd && wbit(CMD_I.word, FORMS_OPEN_BIT);
    assign sol_fire[SOL_CLOSE] = forms_cmd && wbit(CMD_I.word, FORMS_CLOSE_BIT);
    assign sol_fire[SOL_ALARM] = forms_cmd && wbit(CMD_I.word, FORMS_ALARM_BIT);

    // lamp line k comes from command bit LAMP_DATA_BIT0+k
    for (genvar k = 0; k < LAMP_GROUP_W; k++) begin : g_ldata
        assign lamp_data[k] = wbit(CMD_I.word, LAMP_DATA_BIT0 + k);
    end

    // solenoid pulse channels; a retrigger restarts the pulse rather than stretching
    // it unboundedly, so each line is low for PULSE_LEN cycles after its last command
    logic [NUM_SOL-1:0] sol_n_q;
    logic [CNT_W-1:0]   sol_cnt_q [NUM_SOL];
    for (genvar s = 0; s < NUM_SOL; s++) begin : g_sol
        always_ff @(posedge CLK_I) begin
            if (RST_I || SYS_CLEAR_I) begin
                sol_n_q[s]   <= 1'b1;
                sol_cnt_q[s] <= CNT_ZERO;
            end else if (sol_fire[s]) begin
                sol_n_q[s]   <= 1'b0;
                sol_cnt_q[s] <= CNT_LOAD;
            end else if (sol_cnt_q[s] != CNT_ZERO) begin
                sol_cnt_q[s] <= sol_cnt_q[s] - 1'b1;
            end else begin
                sol_n_q[s]   <= 1'b1;
            end
        end
    end
    assign LEFT_FEED_DRIVE_N_O   = sol_n_q[SOL_LEFT];
    assign RIGHT_FEED_DRIVE_N_O  = sol_n_q[SOL_RIGHT];
    assign CHUTE_OPEN_DRIVE_N_O  = sol_n_q[SOL_OPEN];
    assign CHUTE_CLOSE_DRIVE_N_O = sol_n_q[SOL_CLOSE];
    assign ALARM_DRIVE_N_O       = sol_n_q[SOL_ALARM];

    // power-off request latches; only reset withdraws it, system clear does not
    logic power_off_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            power_off_q <= 1'b0;
        end else if (forms_cmd && wbit(CMD_I.word, FORMS_POWER_BIT)) begin
            power_off_q <= 1'b1;
        end
    end
    assign POWER_OFF_O = power_off_q;

    // lamp banks hold their value until rewritten or cleared; held active low in
    // the flops so every lamp pin comes straight from a register, no glitchy inverter
    logic [LAMP_GROUP_W-1:0] lamp_a_n_q, lamp_b_n_q, lamp_c_n_q, lamp_d_n_q;
    logic [LAMP_S_W-1:0]     lamp_s_n_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I || SYS_CLEAR_I) begin
            lamp_a_n_q <= '1;
            lamp_b_n_q <= '1;
            lamp_c_n_q <= '1;
            lamp_d_n_q <= '1;
            lamp_s_n_q <= '1;
        end else if (lamp_cmd) begin
            if (wbit(CMD_I.word, LAMP_BANK_A_BIT)) lamp_a_n_q <= ~lamp_data;
            if (wbit(CMD_I.word, LAMP_BANK_B_BIT)) lamp_b_n_q <= ~lamp_data;
            if (wbit(CMD_I.word, LAMP_BANK_C_BIT)) lamp_c_n_q <= ~lamp_data;
            if (wbit(CMD_I.word, LAMP_BANK_D_BIT)) lamp_d_n_q <= ~lamp_data;
            if (wbit(CMD_I.word, LAMP_BANK_S_BIT)) lamp_s_n_q <= ~lamp_data[LAMP_S_W-1:0];
        end
    end
    assign LAMP_GROUP_A_N_O = lamp_a_n_q;
    assign LAMP_GROUP_B_N_O = lamp_b_n_q;
    assign LAMP_GROUP_C_N_O = lamp_c_n_q;
    assign LAMP_GROUP_D_N_O = lamp_d_n_q;
    assign LAMP_ALPHA_N_O   = lamp_s_n_q[0];
    assign LAMP_READY_N_O   = lamp_s_n_q[1];
    assign LAMP_ERROR_N_O   = lamp_s_n_q[2];
    assign LAMP_NUMERIC_N_O = lamp_s_n_q[3];

    // print head code, held active low directly in the flops
    logic [TILT_W-1:0] tilt_n_q;
    logic [ROT_W-1:0]  rot_n_q;
    logic              rotx_n_q, red_n_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I || SYS_CLEAR_I) begin
            tilt_n_q <= '1;
            rot_n_q  <= '1;
            rotx_n_q <= 1'b1;
            red_n_q  <= 1'b1;
        end else if (print_cmd) begin
            for (int t = 0; t < TILT_W; t++) begin
                tilt_n_q[t] <= ~wbit(CMD_I.word, PRINT_TILT1_BIT + t);
            end
            for (int r = 0; r < ROT_W; r++) begin
                rot_n_q[r] <= ~wbit(CMD_I.word, PRINT_ROT1_BIT + r);
            end
            rotx_n_q <= ~wbit(CMD_I.word, PRINT_ROTX_BIT);
            red_n_q  <= ~wbit(CMD_I.word, PRINT_RED_BIT);
        end
    end
    assign HEAD_TILT_CODE_N_O   = tilt_n_q;
    assign HEAD_ROTATE_CODE_N_O = rot_n_q;

    // ribbon routing by character mode, registered so the outputs are flops
    logic ribbon_ext_n_q, ribbon_wide_n_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ribbon_ext_n_q  <= 1'b1;
            ribbon_wide_n_q <= 1'b1;
        end else begin
            ribbon_ext_n_q  <= MODE_96_I ? rotx_n_q : red_n_q;
            ribbon_wide_n_q <= MODE_96_I ? red_n_q : 1'b1;
        end
    end
    assign RIBBON_OR_ROTATE_EXT_N_O = ribbon_ext_n_q;
    assign RIBBON_SHIFT_WIDE_N_O    = ribbon_wide_n_q;

    // motor and power lamp
    logic motor_n_q, power_lamp_n_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            motor_n_q      <= 1'b1;
            power_lamp_n_q <= 1'b0;
        end else begin
            motor_n_q      <= ~MOTOR_REQ_I;
            power_lamp_n_q <= 1'b0;
        end
    end
    assign DECODER_MOTOR_ON_N_O = motor_n_q;
    assign POWER_LAMP_N_O       = power_lamp_n_q;

    // status flags, all sticky except the data request; a set in the clearing cycle wins
    logic ready_q, nothon_q, armed_q, over_q, stall_q, dreq_q;
    logic err_clr;
    assign err_clr = STATUS_ACK_I || SYS_CLEAR_I;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ready_q  <= 1'b0;
            nothon_q <= 1'b0;
            armed_q  <= 1'b0;
            over_q   <= 1'b0;
            stall_q  <= 1'b0;
            dreq_q   <= 1'b0;
        end else begin
            dreq_q   <= |DINT_I;
            ready_q  <= READY_BTN_I || (ready_q && !SYS_CLEAR_I);
            nothon_q <= (KEY_STROBE_I && KEY_STAGE_FULL_I) || (nothon_q && !err_clr);
            armed_q  <= CARRIER_WORD_I || (armed_q && !SYS_CLEAR_I);
            over_q   <= (armed_q && OVERSPEED_I) || (over_q && !err_clr);
            stall_q  <= (armed_q && STALL_I) || (stall_q && !err_clr);
        end
    end

    // status word assembly; address field bits 4-8 and bit 3 stay zero
    logic [WORD_W-1:0] status_d, status_q;
    always_comb begin
        status_d = STATUS_RESET;
        status_d[WORD_W-ST_DREQ_BIT]   = dreq_q;
        status_d[WORD_W-ST_EOP_BIT]    = EOP_LEFT_I || EOP_RIGHT_I;
        status_d[WORD_W-ST_CARR_BIT]   = DINT_I.carrier;
        status_d[WORD_W-ST_FORMS_BIT]  = DINT_I.forms;
        status_d[WORD_W-ST_PRINT_BIT]  = DINT_I.printer;
        status_d[WORD_W-ST_KBD_BIT]    = DINT_I.keyboard;
        status_d[WORD_W-ST_READY_BIT]  = ready_q;
        status_d[WORD_W-ST_NOTHON_BIT] = nothon_q;
        status_d[WORD_W-ST_OVER_BIT]   = over_q;
        status_d[WORD_W-ST_STALL_BIT]  = stall_q;
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end
    assign STATUS_O = status_q;

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    left_pulse_start_a: assert property (sol_fire[SOL_LEFT] && !SYS_CLEAR_I |=>
        !LEFT_FEED_DRIVE_N_O && sol_cnt_q[SOL_LEFT] == CNT_LOAD)
        else $error("left feed pulse did not start");
    right_pulse_start_a: assert property (sol_fire[SOL_RIGHT] && !SYS_CLEAR_I |=>
        !RIGHT_FEED_DRIVE_N_O)
        else $error("right feed pulse did not start");
    pulse_ends_a: assert property (!ALARM_DRIVE_N_O && sol_cnt_q[SOL_ALARM] == CNT_ZERO
        && !sol_fire[SOL_ALARM] |=> ALARM_DRIVE_N_O)
        else $error("alarm pulse did not end");
    chute_open_a: assert property (sol_fire[SOL_OPEN] && !SYS_CLEAR_I |=>
        !CHUTE_OPEN_DRIVE_N_O) else $error("chute open missing");
    chute_close_a: assert property (sol_fire[SOL_CLOSE] && !SYS_CLEAR_I |=>
        !CHUTE_CLOSE_DRIVE_N_O) else $error("chute close missing");
    power_off_a: assert property (forms_cmd && wbit(CMD_I.word, FORMS_POWER_BIT)
        |=> POWER_OFF_O [*2]) else $error("power off not held");
    dreq_follows_a: assert property ((|DINT_I) |=> ##1 STATUS_O[WORD_W-ST_DREQ_BIT])
        else $error("data request did not follow interrupt");
    eop_status_a: assert property (!$past(RST_I) |-> STATUS_O[WORD_W-ST_EOP_BIT] ==
        $past(EOP_LEFT_I || EOP_RIGHT_I)) else $error("end of paper wrong");
    addr_field_a: assert property (STATUS_O[WORD_W-4:WORD_W-8] == 5'h00)
        else $error("address field not zero");
    kbd_ready_a: assert property (!$past(RST_I) |->
        STATUS_O[WORD_W-ST_KBD_BIT] == $past(DINT_I.keyboard))
        else $error("keyboard ready wrong");
    not_honored_a: assert property (KEY_STROBE_I && KEY_STAGE_FULL_I |=> ##1
        STATUS_O[WORD_W-ST_NOTHON_BIT]) else $error("not honored lost");
    overspeed_a: assert property (!armed_q && !CARRIER_WORD_I ##1 !armed_q |-> !$rose(over_q))
        else $error("overspeed without carrier word");
    lamp_hold_a: assert property (!lamp_cmd && !SYS_CLEAR_I |=> $stable(lamp_a_n_q))
        else $error("lamp bank changed without command");
    ribbon_64_a: assert property (!MODE_96_I |=> RIBBON_SHIFT_WIDE_N_O)
        else $error("wide ribbon active in 64 mode");
    power_lamp_a: assert property (##1 !POWER_LAMP_N_O)
        else $error("power lamp not low");

    forms_cover_c:  cover property (forms_cmd ##1 !LEFT_FEED_DRIVE_N_O);
    lamp_cover_c:   cover property (lamp_cmd ##1 (LAMP_GROUP_A_N_O != 8'hFF));
    stall_cover_c:  cover property (CARRIER_WORD_I ##[1:4] STALL_I ##1 stall_q);
endmodule : console_forms_status_control

// >>> testbench/host_model.sv
`timescale 1ns/1ns
module host_model
    import console_pkg::*;
#(
    parameter logic [4:0] DEV_ADDR = 5'h15 // port address merged on the return path
) (
    input  wire logic              clk_i,         // system clock
    input  wire logic [WORD_W-1:0] status_i,      // raw status word from the block
    output console_pkg::cmd_type   cmd_o,         // command strobe and word
    output logic [WORD_W-1:0]      status_seen_o  // status as the processor reads it
);
    initial cmd_o = '0;
    // port selector owns bits 4-8; the block must leave them zero or the OR corrupts it
    assign status_seen_o = status_i | {3'h0, DEV_ADDR, 8'h00};
    // one-cycle strobe on falling edges; the caller sets the function field in bits 1-2
    task send(input logic [WORD_W-1:0] w);
        @(negedge clk_i);
        cmd_o = '{valid: 1'b1, word: w};
        @(negedge clk_i);
        cmd_o.valid = 1'b0;
    endtask : send
endmodule : host_model

// >>> testbench/tb.sv
`timescale 1ns/1ns
module tb;
    import console_pkg::*;
    localparam int          PL = 8;          // short solenoid pulse for simulation
    localparam logic [15:0] AF = 16'h1500;   // address field the host merges in
    localparam int          SB [5] = '{10, 12, 13, 14, 16};
    logic        clk, rst, sys_clear, eop_l, eop_r, ready_btn, key_strobe, key_full;
    logic        carr_word, over, stall, ack, mode96, motor;
    logic        power_off, left_n, right_n, open_n, close_n, alarm_n, ext_n, wide_n;
    logic        alpha_n, ready_n, error_n, num_n, motor_n, plamp_n;
    logic [7:0]  la, lb, lc, ld;
    logic [1:0]  tilt_n;
    logic [3:0]  rot_n;
    logic [15:0] status, seen;
    dint_type    dint;
    cmd_type     cmd;
    int          n_fail = 0;
    int          check_count = 0;
    int          i;
    wire  [4:0]  sol = {left_n, right_n, open_n, close_n, alarm_n};
    wire  [3:0]  lamp_s = {alpha_n, ready_n, error_n, num_n};

    task check(input string nm, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, well beyond the hundred or so cycles the sequence needs
    initial begin
        #(3000 * 50);
        n_fail++;
        close_out();
    end

    host_model #(.DEV_ADDR(5'h15)) host_model_i (
        .clk_i(clk), .status_i(status), .cmd_o(cmd), .status_seen_o(seen));

    console_forms_status_control #(.PULSE_LEN(PL)) console_forms_status_control_i (
        .CLK_I(clk), .RST_I(rst), .SYS_CLEAR_I(sys_clear), .CMD_I(cmd), .DINT_I(dint),
        .EOP_LEFT_I(eop_l), .EOP_RIGHT_I(eop_r), .READY_BTN_I(ready_btn),
        .KEY_STROBE_I(key_strobe), .KEY_STAGE_FULL_I(key_full), .CARRIER_WORD_I(carr_word),
        .OVERSPEED_I(over), .STALL_I(stall), .STATUS_ACK_I(ack), .MODE_96_I(mode96),
        .MOTOR_REQ_I(motor), .STATUS_O(status), .POWER_OFF_O(power_off),
        .LEFT_FEED_DRIVE_N_O(left_n), .RIGHT_FEED_DRIVE_N_O(right_n),
        .CHUTE_OPEN_DRIVE_N_O(open_n), .CHUTE_CLOSE_DRIVE_N_O(close_n),
        .ALARM_DRIVE_N_O(alarm_n), .LAMP_GROUP_A_N_O(la), .LAMP_GROUP_B_N_O(lb),
        .LAMP_GROUP_C_N_O(lc), .LAMP_GROUP_D_N_O(ld), .LAMP_ALPHA_N_O(alpha_n),
        .LAMP_READY_N_O(ready_n), .LAMP_ERROR_N_O(error_n), .LAMP_NUMERIC_N_O(num_n),
        .HEAD_TILT_CODE_N_O(tilt_n), .HEAD_ROTATE_CODE_N_O(rot_n),
        .RIBBON_OR_ROTATE_EXT_N_O(ext_n), .RIBBON_SHIFT_WIDE_N_O(wide_n),
        .DECODER_MOTOR_ON_N_O(motor_n), .POWER_LAMP_N_O(plamp_n));

    // main sequence: inputs change on falling edges only
    initial begin
        rst = 1'b1;
        sys_clear = 1'b0;
        eop_l = 1'b0;
        eop_r = 1'b0;
        ready_btn = 1'b0;
        key_strobe = 1'b0;
        key_full = 1'b0;
        carr_word = 1'b0;
        over = 1'b0;
        stall = 1'b0;
        ack = 1'b0;
        mode96 = 1'b0;
        motor = 1'b0;
        dint = '0;
        tick(3);
        rst = 1'b0;
        check("status reset", seen, AF);
        check("solenoids reset", 16'(sol), 16'h001F);
        check("power lamp", 16'(plamp_n), 16'h0000);
        // unused forms bits and function 00 must do nothing
        host_model_i.send(16'hC000 | 16'h3FA0);
        check("unused bits", 16'(sol), 16'h001F);
        host_model_i.send(16'h3FFF);
        tick(1);
        check("func 00", 16'(sol), 16'h001F);
        check("power idle", 16'(power_off), 16'h0000);
        for (i = 0; i < 5; i++) begin
            host_model_i.send(16'hC000 | (16'h0001 << (16 - SB[i])));
            check("solenoid on", 16'(sol), 16'(5'h1F ^ (5'h10 >> i)));
            tick(PL - 1);
            check("solenoid held", 16'(sol), 16'(5'h1F ^ (5'h10 >> i)));
            tick(1);
            check("solenoid off", 16'(sol), 16'h001F);
        end
        host_model_i.send(16'hC002); // forms word, bit 15 alone
        check("power off", 16'(power_off), 16'h0001);
        // banks A and C together, then A alone rewritten with zero
        host_model_i.send(16'h9403);
        check("lamp A", 16'(la), 16'h003F);
        check("lamp B", 16'(lb), 16'h00FF);
        host_model_i.send(16'h9000);
        check("lamp A cleared", 16'(la), 16'h00FF);
        check("lamp C kept", 16'(lc), 16'h003F);
        host_model_i.send(16'h8190);
        check("lamp S", 16'(lamp_s), 16'h0006);
        // banks B and D together, lines 0 and 7
        host_model_i.send(16'h8A81);
        check("lamp B D", {lb, ld}, 16'h7E7E);
        // print word: tilt 1, rotate 2 and 8, red ribbon
        host_model_i.send(16'h6540);
        check("tilt", 16'(tilt_n), 16'h0002);
        check("rotate", 16'(rot_n), 16'h0005);
        tick(1);
        check("ribbon 64", 16'({ext_n, wide_n}), 16'h0001);
        mode96 = 1'b1;
        host_model_i.send(16'h6540);
        tick(1);
        check("ribbon 96", 16'({ext_n, wide_n}), 16'h0002);
        sys_clear = 1'b1;
        tick(1);
        sys_clear = 1'b0;
        tick(1);
        check("clear lamps", {la, lc}, 16'hFFFF);
        check("clear S", 16'(lamp_s), 16'h000F);
        check("power kept", 16'(power_off), 16'h0001);
        motor = 1'b1;
        tick(1);
        check("motor on", 16'(motor_n), 16'h0000);
        // each data interrupt alone, bit 1 follows two cycles later
        for (i = 0; i < 4; i++) begin
            dint = dint_type'(4'h8 >> i);
            tick(2);
            check("interrupts", seen, AF | 16'h8000 | (16'(dint) << 4));
        end
        // bit 1 lags the interrupts by two cycles, so wait it out
        dint = '0;
        eop_l = 1'b1;
        tick(2);
        check("paper left", seen, AF | 16'h4000);
        eop_l = 1'b0;
        eop_r = 1'b1;
        tick(1);
        check("paper right", seen, AF | 16'h4000);
        eop_r = 1'b0;
        ready_btn = 1'b1;
        tick(1);
        ready_btn = 1'b0;
        tick(2);
        check("ready", seen, AF | 16'h0008);
        over = 1'b1;
        stall = 1'b1;
        tick(3);
        check("not armed", seen, AF | 16'h0008);
        carr_word = 1'b1;
        tick(1);
        carr_word = 1'b0;
        tick(3);
        check("over stall", seen, AF | 16'h000B);
        over = 1'b0;
        stall = 1'b0;
        key_full = 1'b1;
        key_strobe = 1'b1;
        tick(1);
        key_full = 1'b0;
        key_strobe = 1'b0;
        tick(2);
        check("not honored", seen, AF | 16'h000F);
        ack = 1'b1;
        tick(1);
        ack = 1'b0;
        tick(2);
        check("ack", seen, AF | 16'h0008);
        sys_clear = 1'b1;
        tick(1);
        sys_clear = 1'b0;
        tick(2);
        check("clear status", seen, AF);
        close_out();
    end
endmodule : tb
